// file: hw/pfd_pkg.sv
// package: register map, field layout, reset values and timing counts of the pll3 config block
package pfd_pkg;
  // register offsets on the configuration port
  localparam logic [7:0] ADDR_S0_RQ   = 8'h3a;
  localparam logic [7:0] ADDR_S0_QPB  = 8'h3b;
  localparam logic [7:0] ADDR_S1_NHI  = 8'h3c;
  localparam logic [7:0] ADDR_S1_NLR  = 8'h3d;
  localparam logic [7:0] ADDR_S1_RQ   = 8'h3e;
  localparam logic [7:0] ADDR_S1_QPB  = 8'h3f;
  // reset values (quotient 16, exponent 2, feedback 4, remainder 0)
  localparam logic [7:0] RST_RQ       = 8'h02;
  localparam logic [7:0] RST_QPB      = 8'h08;
  localparam logic [7:0] RST_NHI      = 8'h00;
  localparam logic [7:0] RST_NLR      = 8'h40;
  // field positions inside the packed bytes
  localparam int RQ_REM_LSB  = 3;
  localparam int QPB_Q_LSB   = 5;
  localparam int QPB_P_LSB   = 2;
  localparam int NLR_N_LSB   = 4;
  // fractional divider limits
  localparam logic [2:0]  EXP_BASE  = 3'd4;
  localparam logic [15:0] Q_MIN     = 16'd16;
  localparam logic [15:0] Q_MAX     = 16'd63;
  // vco band edges and legal vco range, in kHz
  localparam logic [31:0] BAND1_KHZ   = 32'd125000;
  localparam logic [31:0] BAND2_KHZ   = 32'd150000;
  localparam logic [31:0] BAND3_KHZ   = 32'd175000;
  localparam logic [31:0] VCO_MIN_KHZ = 32'd80000;
  localparam logic [31:0] VCO_MAX_KHZ = 32'd230000;
  // spread spectrum timing: triangle period must stay below 1/20 kHz
  localparam int CLK_HZ           = 25000000;
  localparam int SSC_MIN_RATE_HZ  = 20000;
  localparam int SSC_MAX_PER_CYC  = CLK_HZ / SSC_MIN_RATE_HZ;
  localparam int SSC_AMT_MAX      = 127;
  localparam logic [2:0] SSC_DIV_MAX = 3'(SSC_MAX_PER_CYC / (2 * SSC_AMT_MAX) - 1);
  // one configuration set as applied to the synthesizer
  typedef struct packed {
    logic [11:0] feedback;
    logic [8:0]  remainder;
    logic [5:0]  quotient;
    logic [2:0]  exponent;
    logic [1:0]  band;
  } pfd_cfg_t;
  // calculator results
  typedef struct packed {
    logic [2:0]  exponent;
    logic [15:0] quotient;
    logic [9:0]  remainder;
    logic [31:0] fvco_khz;
    logic [31:0] fout_khz;
    logic [1:0]  band;
    logic        ratio_ok;
    logic        vco_ok;
    logic        out_ok;
  } pfd_calc_t;
  // calculator sequencer, gray along the path
  typedef enum logic [2:0] {
    CALC_IDLE = 3'b000,
    CALC_DIVQ = 3'b001,
    CALC_DIVV = 3'b011,
    CALC_DIVO = 3'b010,
    CALC_DONE = 3'b110
  } pfd_calc_state_t;
endpackage

// file: hw/pfd_pll3_config.sv
// pll3 fractional divider configuration: two sets, apply logic, ratio calculator, ssc shaper
`timescale 1ns/1ps
`default_nettype none
module pfd_pll3_config
  import pfd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        nv_wr,
  input  wire logic [7:0]  nv_addr,
  input  wire logic [7:0]  nv_data,
  input  wire logic        nv_done,
  input  wire logic [11:0] set0_feedback_value,
  input  wire logic [3:0]  set0_remainder_high,
  input  wire logic        set_select_pin,
  output pfd_cfg_t         active_cfg,
  output logic             active_set,
  output logic             apply_pulse,
  input  wire logic        calc_start,
  input  wire logic [11:0] calc_feedback,
  input  wire logic [8:0]  calc_reference,
  input  wire logic [6:0]  calc_out_div,
  input  wire logic [17:0] calc_fin_khz,
  output logic             calc_busy,
  output logic             calc_done,
  output pfd_calc_t        calc_result,
  input  wire logic        ssc_enable,
  input  wire logic        ssc_center,
  input  wire logic [6:0]  ssc_amount,
  input  wire logic [2:0]  ssc_rate_sel,
  output logic signed [7:0] ssc_offset
);
  logic            rst_s1_reg, rst_n;
  logic [7:0]      s0_rq_reg, s0_qpb_reg, s1_nhi_reg, s1_nlr_reg, s1_rq_reg, s1_qpb_reg;
  logic            wr_en;
  logic [7:0]      wr_addr, wr_data;
  logic            sel_s1_reg, sel_s2_reg, sel_s3_reg, sel_reg;
  logic            apply_req;
  pfd_cfg_t        set0_view, set1_view;
  pfd_calc_state_t st_reg;
  logic [9:0]      rem_reg;
  logic [31:0]     quo_reg;
  logic [8:0]      dvs_reg;
  logic [4:0]      cnt_reg;
  logic [10:0]     sh_next;
  logic            bit_next;
  logic [9:0]      rem_next;
  logic [31:0]     quo_next;
  logic [3:0]      lg2;
  logic [2:0]      exp_calc;
  logic [2:0]      div_cnt_reg;
  logic [6:0]      tri_reg;
  logic            tri_up_reg;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // serial port wins over the nonvolatile loader on a shared cycle
  assign wr_en   = cfg_wr | nv_wr;
  assign wr_addr = cfg_wr ? cfg_addr : nv_addr;
  assign wr_data = cfg_wr ? cfg_wdata : nv_data;

  // byte registers of both sets
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s0_rq_reg  <= RST_RQ;
      s0_qpb_reg <= RST_QPB;
      s1_nhi_reg <= RST_NHI;
      s1_nlr_reg <= RST_NLR;
      s1_rq_reg  <= RST_RQ;
      s1_qpb_reg <= RST_QPB;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        ADDR_S0_RQ:  s0_rq_reg  <= wr_data;
        ADDR_S0_QPB: s0_qpb_reg <= wr_data;
        ADDR_S1_NHI: s1_nhi_reg <= wr_data;
        ADDR_S1_NLR: s1_nlr_reg <= wr_data;
        ADDR_S1_RQ:  s1_rq_reg  <= wr_data;
        ADDR_S1_QPB: s1_qpb_reg <= wr_data;
        default:     ;
      endcase
    end
  end

  // register read, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
      begin
        case (cfg_addr)
          ADDR_S0_RQ:  cfg_rdata <= s0_rq_reg;
          ADDR_S0_QPB: cfg_rdata <= s0_qpb_reg;
          ADDR_S1_NHI: cfg_rdata <= s1_nhi_reg;
          ADDR_S1_NLR: cfg_rdata <= s1_nlr_reg;
          ADDR_S1_RQ:  cfg_rdata <= s1_rq_reg;
          ADDR_S1_QPB: cfg_rdata <= s1_qpb_reg;
          default:     cfg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // unpack both sets into field views
  assign set0_view.feedback  = set0_feedback_value;
  assign set0_view.remainder = {set0_remainder_high, s0_rq_reg[7:RQ_REM_LSB]};
  assign set0_view.quotient  = {s0_rq_reg[2:0], s0_qpb_reg[7:QPB_Q_LSB]};
  assign set0_view.exponent  = s0_qpb_reg[4:QPB_P_LSB];
  assign set0_view.band      = s0_qpb_reg[1:0];
  assign set1_view.feedback  = {s1_nhi_reg, s1_nlr_reg[7:NLR_N_LSB]};
  assign set1_view.remainder = {s1_nlr_reg[3:0], s1_rq_reg[7:RQ_REM_LSB]};
  assign set1_view.quotient  = {s1_rq_reg[2:0], s1_qpb_reg[7:QPB_Q_LSB]};
  assign set1_view.exponent  = s1_qpb_reg[4:QPB_P_LSB];
  assign set1_view.band      = s1_qpb_reg[1:0];

  // set select pin: three stages, a change counts once stage two and three agree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
      sel_s3_reg <= 1'b0;
      sel_reg    <= 1'b0;
    end
    else
    begin
      sel_s1_reg <= set_select_pin;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      if (sel_s2_reg == sel_s3_reg)
        sel_reg <= sel_s3_reg;
    end
  end

  // apply on closing byte of the selected set, on set change or after a store load
  assign apply_req = (wr_en && !sel_reg && wr_addr == ADDR_S0_QPB) ||
                     (wr_en && sel_reg && wr_addr == ADDR_S1_QPB) ||
                     (sel_s2_reg == sel_s3_reg && sel_s3_reg != sel_reg) || nv_done;

  // active set is taken whole, two cycles after the request, on the edge after the apply pulse
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_cfg  <= '0;
      active_set  <= 1'b0;
      apply_pulse <= 1'b1;
    end
    else
    begin
      apply_pulse <= apply_req | apply_pulse & (active_cfg == '0);
      if (apply_pulse)
      begin
        active_cfg <= sel_reg ? set1_view : set0_view;
      end
      active_set <= sel_reg;
    end
  end

  // exponent: four minus the largest k with reference shifted by k not above feedback, floored at zero
  always_comb
  begin
    lg2 = 4'd0;
    for (int k = 1; k < 12; k++)
    begin
      if (({11'd0, calc_reference} << k) <= {8'd0, calc_feedback})
        lg2 = 4'(k);
    end
    exp_calc = (lg2 >= 4'(EXP_BASE)) ? 3'd0 : EXP_BASE - lg2[2:0];
  end

  // one restoring divide step
  assign sh_next  = {rem_reg, quo_reg[31]};
  assign bit_next = sh_next >= {2'd0, dvs_reg};
  assign rem_next = bit_next ? 10'(sh_next - {2'd0, dvs_reg}) : sh_next[9:0];
  assign quo_next = {quo_reg[30:0], bit_next};
  assign calc_busy = (st_reg != CALC_IDLE) && (st_reg != CALC_DONE);

  // calculator: quotient and remainder, then vco, then output frequency
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg      <= CALC_IDLE;
      rem_reg     <= '0;
      quo_reg     <= '0;
      dvs_reg     <= '0;
      cnt_reg     <= '0;
      calc_done   <= 1'b0;
      calc_result <= '0;
    end
    else
    begin
      calc_done <= 1'b0;
      case (st_reg)
        CALC_IDLE, CALC_DONE:
        begin
          if (calc_start)
          begin
            calc_result.exponent <= exp_calc;
            quo_reg <= 32'({calc_feedback, 4'd0} >> (EXP_BASE - exp_calc));
            rem_reg <= '0;
            dvs_reg <= calc_reference;
            cnt_reg <= 5'd31;
            st_reg  <= CALC_DIVQ;
          end
        end
        CALC_DIVQ, CALC_DIVV, CALC_DIVO:
        begin
          quo_reg <= quo_next;
          rem_reg <= rem_next;
          cnt_reg <= cnt_reg - 5'd1;
          if (cnt_reg == 5'd0)
          begin
            rem_reg <= '0;
            cnt_reg <= 5'd31;
            if (st_reg == CALC_DIVQ)
            begin
              calc_result.quotient  <= quo_next[15:0];
              calc_result.remainder <= rem_next;
              calc_result.ratio_ok  <= calc_reference != 9'd0 && calc_feedback != 12'd0 &&
                                       calc_feedback >= {3'd0, calc_reference} &&
                                       quo_next[15:0] >= Q_MIN && quo_next[15:0] <= Q_MAX;
              quo_reg <= 32'(calc_fin_khz * calc_feedback);
              st_reg  <= CALC_DIVV;
            end
            else if (st_reg == CALC_DIVV)
            begin
              calc_result.fvco_khz <= quo_next;
              calc_result.vco_ok   <= quo_next >= VCO_MIN_KHZ && quo_next <= VCO_MAX_KHZ;
              calc_result.band     <= quo_next < BAND1_KHZ ? 2'b00 :
                                      quo_next < BAND2_KHZ ? 2'b01 :
                                      quo_next < BAND3_KHZ ? 2'b10 : 2'b11;
              quo_reg <= quo_next;
              dvs_reg <= {2'd0, calc_out_div};
              st_reg  <= CALC_DIVO;
            end
            else
            begin
              calc_result.fout_khz <= quo_next;
              calc_result.out_ok   <= dvs_reg != 9'd0;
              calc_done <= 1'b1;
              st_reg    <= CALC_DONE;
            end
          end
        end
        default: st_reg <= CALC_IDLE;
      endcase
    end
  end

  // spread spectrum rate divider, clamped so the triangle stays above the minimum rate
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_reg <= '0;
    else if (div_cnt_reg == '0)
      div_cnt_reg <= (ssc_rate_sel > SSC_DIV_MAX) ? SSC_DIV_MAX : ssc_rate_sel;
    else
      div_cnt_reg <= div_cnt_reg - 3'd1;
  end

  // triangle between zero and the amount, stepped on the divider enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tri_reg    <= '0;
      tri_up_reg <= 1'b1;
    end
    else if (!ssc_enable)
    begin
      tri_reg    <= '0;
      tri_up_reg <= 1'b1;
    end
    else if (div_cnt_reg == '0)
    begin
      if (tri_reg > ssc_amount)
        tri_reg <= ssc_amount;
      else if (tri_up_reg)
      begin
        if (tri_reg >= ssc_amount)
          tri_up_reg <= 1'b0;
        else
          tri_reg <= tri_reg + 7'd1;
      end
      else if (tri_reg == '0)
        tri_up_reg <= 1'b1;
      else
        tri_reg <= tri_reg - 7'd1;
    end
  end

  // offset: down spread goes negative, center spread swings about zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ssc_offset <= '0;
    else if (ssc_center)
      ssc_offset <= 8'(signed'({1'b0, tri_reg}) - signed'({2'b00, ssc_amount[6:1]}));
    else
      ssc_offset <= 8'(-signed'({1'b0, tri_reg}));
  end

  AST_APPLY_WHOLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(active_cfg) |-> $past(apply_pulse))
    else $error("active set changed without apply");
  AST_SET1_FIELDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    apply_pulse && sel_reg && !wr_en |=>
    active_cfg.feedback == {s1_nhi_reg, s1_nlr_reg[7:NLR_N_LSB]})
    else $error("set1 feedback not packed right");
  AST_SET0_FIELDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    apply_pulse && !sel_reg && !wr_en |=>
    active_cfg.quotient == {s0_rq_reg[2:0], s0_qpb_reg[7:QPB_Q_LSB]})
    else $error("set0 quotient not packed right");
  AST_BAND_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    calc_done |-> (calc_result.band == 2'b00) == (calc_result.fvco_khz < BAND1_KHZ))
    else $error("band code wrong at 125 MHz edge");
  AST_EXP_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    calc_done |-> calc_result.exponent <= EXP_BASE)
    else $error("exponent above four");
  AST_REM_BELOW_REF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg == CALC_DIVQ && cnt_reg == 5'd0 && dvs_reg != 9'd0 |=>
    calc_result.remainder < {1'b0, dvs_reg})
    else $error("remainder not below reference");
  AST_VCO_WINDOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    calc_done && calc_result.vco_ok |-> calc_result.fvco_khz inside {[VCO_MIN_KHZ:VCO_MAX_KHZ]})
    else $error("vco flagged legal outside 80..230 MHz");
  AST_CALC_TIME: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_reg == CALC_IDLE || st_reg == CALC_DONE) && calc_start |-> ##97 calc_done)
    else $error("calculation not done 97 cycles after start");
  AST_TRI_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ssc_enable && $stable(ssc_amount) ##1 ssc_enable |->
    tri_reg <= ssc_amount || $past(tri_reg > ssc_amount))
    else $error("triangle past amount");
  AST_SEL_AGREE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(sel_reg) |-> $past(sel_s2_reg == sel_s3_reg))
    else $error("set select moved before stages agreed");
  COV_CALC_OK: cover property (@(posedge ref_clk) disable iff (!rst_n)
    calc_done && calc_result.ratio_ok && calc_result.vco_ok);
  COV_SET_SWITCH: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(sel_reg) && apply_pulse);
  COV_TRI_TURN: cover property (@(posedge ref_clk) disable iff (!rst_n)
    ssc_enable && $fell(tri_up_reg));
endmodule
`default_nettype wire

// file: verif/pfd_nv_store_model.sv
// nonvolatile store model: streams a stored set1 image into the register file, then flags done
`timescale 1ns/1ps
`default_nettype none
module pfd_nv_store_model
  import pfd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       slow,
  output logic            nv_wr,
  output logic      [7:0] nv_addr,
  output logic      [7:0] nv_data,
  output logic            nv_done,
  output logic            busy
);
  logic [2:0] idx_reg;
  logic       tick_reg;
  // stored image: feedback 11, remainder 0, quotient 22, exponent 2, band 1
  function automatic logic [7:0] image(input logic [2:0] i);
    case (i)
      3'd0:    return 8'h00;
      3'd1:    return 8'hb0;
      3'd2:    return 8'h02;
      default: return 8'hc9;
    endcase
  endfunction
  // byte sequencer; idle lines toggle so a stale byte never looks valid
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_reg <= 3'd0;
      tick_reg <= 1'b0;
      busy <= 1'b0;
      nv_wr <= 1'b0;
      nv_done <= 1'b0;
      nv_addr <= 8'h00;
      nv_data <= 8'h00;
    end
    else
    begin
      nv_wr <= 1'b0;
      nv_done <= 1'b0;
      tick_reg <= ~tick_reg;
      if (start && !busy)
      begin
        busy <= 1'b1;
        idx_reg <= 3'd0;
      end
      else if (busy && (!slow || tick_reg))
      begin
        if (idx_reg == 3'd4)
        begin
          nv_done <= 1'b1;
          busy <= 1'b0;
        end
        else
        begin
          nv_wr <= 1'b1;
          nv_addr <= 8'h3c + {5'd0, idx_reg};
          nv_data <= image(idx_reg);
          idx_reg <= idx_reg + 3'd1;
        end
      end
      else
      begin
        nv_addr <= ~nv_addr;
        nv_data <= ~nv_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/pll_fractional_divider_config_test.sv
// testbench: register map, set apply, ratio calculator and spread shaper of the pll3 block
`timescale 1ns/1ps
`default_nettype none
module pll_fractional_divider_config_test
  import pfd_pkg::*;
;
  logic ref_clk, rstn, cfg_wr, cfg_rd, cfg_rvalid, nv_wr, nv_done, sel_pin;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, nv_addr, nv_data;
  logic [11:0] s0_fb, c_fb;
  logic [3:0] s0_rh;
  pfd_cfg_t active_cfg;
  pfd_calc_t calc_result;
  logic active_set, apply_pulse, calc_start, calc_busy, calc_done;
  logic [8:0] c_ref;
  logic [6:0] c_pd, ssc_amount;
  logic [17:0] c_fin;
  logic ssc_enable, ssc_center, nv_start, nv_slow, nv_busy;
  logic [2:0] ssc_rate_sel;
  logic signed [7:0] ssc_offset;
  int err_total, checks_done;

  pfd_pll3_config pfd_pll3_config_i (.ref_clk(ref_clk), .rstn(rstn), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_data(nv_data),
    .nv_done(nv_done), .set0_feedback_value(s0_fb), .set0_remainder_high(s0_rh),
    .set_select_pin(sel_pin), .active_cfg(active_cfg), .active_set(active_set),
    .apply_pulse(apply_pulse), .calc_start(calc_start), .calc_feedback(c_fb),
    .calc_reference(c_ref), .calc_out_div(c_pd), .calc_fin_khz(c_fin),
    .calc_busy(calc_busy), .calc_done(calc_done), .calc_result(calc_result),
    .ssc_enable(ssc_enable), .ssc_center(ssc_center), .ssc_amount(ssc_amount),
    .ssc_rate_sel(ssc_rate_sel), .ssc_offset(ssc_offset));
  pfd_nv_store_model pfd_nv_store_model_i (.ref_clk(ref_clk), .rstn(rstn), .start(nv_start),
    .slow(nv_slow), .nv_wr(nv_wr), .nv_addr(nv_addr), .nv_data(nv_data),
    .nv_done(nv_done), .busy(nv_busy));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one write strobe; an idle edge first keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycles(1);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cycles(1);
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cycles(1);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cycles(1);
    cfg_rd = 1'b0;
    chk({31'd0, cfg_rvalid}, 32'd1);
    chk({24'd0, cfg_rdata}, {24'd0, exp});
  endtask

  // reset image of every byte, unmapped reads as zero
  task automatic test_reset_regs();
    logic [7:0] v [7] = '{8'h02, 8'h08, 8'h00, 8'h40, 8'h02, 8'h08, 8'h00};
    for (int i = 0; i < 7; i++)
      rd(8'h3a + 8'(i), v[i]);
    chk(active_cfg, {12'h004, 9'h000, 6'd16, 3'd2, 2'd0});
  endtask

  task automatic test_set1();
    sel_pin = 1'b1;
    cycles(8);
    chk({31'd0, active_set}, 32'd1);
    wr(8'h3c, 8'ha5);
    wr(8'h3d, 8'h37);
    wr(8'h3e, 8'h9f);
    chk(active_cfg, {12'h004, 9'h000, 6'd16, 3'd2, 2'd0});
    wr(8'h3f, 8'hff);
    chk({31'd0, apply_pulse}, 32'd1);
    cycles(1);
    chk(active_cfg, {12'ha53, 9'h0f3, 6'd63, 3'd7, 2'd3});
    rd(8'h3d, 8'h37);
  endtask

  task automatic test_set0();
    sel_pin = 1'b0;
    s0_fb = 12'h006;
    s0_rh = 4'h9;
    cycles(8);
    wr(8'h3a, 8'h2d);
    chk(active_cfg, {12'h006, 9'h120, 6'd16, 3'd2, 2'd0});
    wr(8'h3b, 8'hae);
    cycles(1);
    chk(active_cfg, {12'h006, 9'h125, 6'd45, 3'd3, 2'd2});
  endtask

  // store load, slow pace, ends in a forced apply of set1
  task automatic test_nv();
    sel_pin = 1'b1;
    nv_slow = 1'b1;
    cycles(8);
    nv_start = 1'b1;
    cycles(2);
    nv_start = 1'b0;
    for (int k = 0; k < 40 && nv_busy; k++)
      cycles(1);
    chk({31'd0, nv_busy}, 32'd0);
    cycles(3);
    chk(active_cfg, {12'h00b, 9'h000, 6'd22, 3'd2, 2'd1});
  endtask

  task automatic test_calc(input int n, input int m, input int pd, input int fin);
    int r, p, ns, q, rm, fv, k;
    r = n / m;
    p = 4;
    while (r > 1)
    begin
      r = r >> 1;
      p--;
    end
    p = (p < 0) ? 0 : p;
    ns = n << p;
    q = ns / m;
    rm = ns - m * q;
    fv = fin * n / m;
    c_fb = 12'(n);
    c_ref = 9'(m);
    c_pd = 7'(pd);
    c_fin = 18'(fin);
    calc_start = 1'b1;
    cycles(1);
    calc_start = 1'b0;
    k = 0;
    while (calc_done !== 1'b1 && k < 200)
    begin
      cycles(1);
      k++;
      calc_start = (k == 10);
      if (k == 50)
        chk({31'd0, calc_busy}, 32'd1);
    end
    chk(k, 96);
    chk(calc_result.exponent, p);
    chk(calc_result.quotient, q);
    chk(calc_result.remainder, rm);
    chk(calc_result.fvco_khz, fv);
    if (pd != 0)
      chk(calc_result.fout_khz, fv / pd);
    chk(calc_result.band, fv >= BAND3_KHZ ? 3 : fv >= BAND2_KHZ ? 2 : fv >= BAND1_KHZ);
    chk(calc_result.vco_ok, fv >= VCO_MIN_KHZ && fv <= VCO_MAX_KHZ);
    chk(calc_result.ratio_ok, n >= m && q >= 16 && q <= 63);
    chk(calc_result.out_ok, pd != 0);
  endtask

  // triangle extremes over several periods, down then center
  task automatic test_ssc(input logic c, input logic [7:0] emn, input logic [7:0] emx);
    logic signed [7:0] mn, mx;
    mn = 8'sd127;
    mx = -8'sd128;
    ssc_enable = 1'b1;
    ssc_center = c;
    ssc_amount = 7'd4;
    cycles(20);
    repeat (100)
    begin
      cycles(1);
      mn = (ssc_offset < mn) ? ssc_offset : mn;
      mx = (ssc_offset > mx) ? ssc_offset : mx;
    end
    chk({24'd0, mn}, {24'd0, emn});
    chk({24'd0, mx}, {24'd0, emx});
    ssc_enable = 1'b0;
  endtask

  // slowest rate select is clamped: steps come every SSC_DIV_MAX + 1 cycles
  task automatic test_ssc_rate();
    logic signed [7:0] last;
    int n;
    ssc_rate_sel = 3'd7;
    ssc_center = 1'b0;
    ssc_amount = 7'd4;
    cycles(2);
    ssc_enable = 1'b1;
    last = ssc_offset;
    n = 0;
    while (ssc_offset === last && n < 50)
    begin
      cycles(1);
      n++;
    end
    last = ssc_offset;
    n = 0;
    while (ssc_offset === last && n < 50)
    begin
      cycles(1);
      n++;
    end
    chk(n, SSC_DIV_MAX + 1);
    ssc_enable = 1'b0;
    ssc_rate_sel = 3'd0;
  endtask

  // watchdog
  initial
  begin
    #800000;
    err_total++;
    conclude();
  end

  initial
  begin
    {ref_clk, rstn, cfg_wr, cfg_rd, sel_pin, calc_start, nv_start, nv_slow} = '0;
    {cfg_addr, cfg_wdata, s0_rh, c_fb, c_ref, c_pd, c_fin} = '0;
    {ssc_enable, ssc_center, ssc_amount, ssc_rate_sel} = '0;
    s0_fb = 12'h004;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    cycles(8);
    test_reset_regs();
    test_set1();
    test_set0();
    test_nv();
    test_calc(4, 1, 2, 27000);
    test_calc(11, 2, 2, 27000);
    test_calc(100, 3, 3, 9000);
    test_calc(6, 1, 2, 27000);
    test_calc(3, 5, 0, 27000);
    test_ssc(1'b0, 8'hfc, 8'h00);
    test_ssc(1'b1, 8'hfe, 8'h02);
    test_ssc_rate();
    conclude();
  end
endmodule
`default_nettype wire
